// >>> core/asp_uart.sv
// 16550-style serial port with APB registers, 64-entry queues and modem lines
// How it works
// RL1: CPU bytes become serial frames; received frames become bytes to read back.
// RL2: Character length programmable from five to eight data bits.
// RL3: Stop bits programmable as 1, 1.5 or 2.
// RL4: Optional parity sent and checked; format and interrupts set by registers.
// RL5: Bit timing from a baud generator with a 16-bit divisor.
// RL6: 8-bit scratch register reads back, no effect on serial operation.
// RL7: 16550 mode uses queues; 16450 mode holds single characters.
// RL8: With queues on, transmit and receive each hold 64 bytes.
// RL9: One interrupt output, causes ranked by fixed priority, highest reported.
// RL10: Each cause has its own enable; disabled causes never interrupt.
// RL11: Causes: transmit, receive, modem status changes, line status.
// RL12: Transmit-holding-empty interrupt says transmit side accepts data.
// RL13: Drives request-to-send and terminal-ready; samples the four modem inputs.
// RL14: Software (XON/XOFF) and hardware (clear-to-send) flow control pause sending.
// RL15: Loop-back returns transmitted data internally to the receiver.
// RL16: Frame is low start, data LSB first, optional parity, high stops.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "asp_defines.svh"
module asp_uart
  import asp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_line,
  input wire logic clear_to_send_in,
  input wire logic set_ready_in,
  input wire logic carrier_detect_in,
  input wire logic ring_indicator_in,
  output logic serial_out_line,
  output logic request_to_send_out,
  output logic terminal_ready_out,
  output logic irq
);

  function automatic logic mapped(input logic [7:0] a);
    return a <= `ASP_OFS_FLOW && a[1:0] == 2'b00;
  endfunction

  function automatic logic par_bit(input asp_lcr_s l, input logic [7:0] d);
    logic p;
    p = ^(d & (8'hff >> (2'h3 - l.wls)));
    if (l.stick) return ~l.eps;
    return l.eps ? p : ~p;
  endfunction

  asp_lcr_s lcr;
  logic [3:0] ier;
  logic [5:0] mcr;
  logic [7:0] scr, dll, dlm;
  logic fifo_en, flow_sw, tx_paused;
  logic [1:0] rx_trig;
  logic [7:0] txq [0:63];
  asp_rxword_s rxq [0:63];
  logic [5:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [6:0] tx_cnt, rx_cnt, cap, trig;
  logic oe, pe, fe, bi, rx_err, thre_pend, thre_q;
  logic [4:0] s1, s2, s3, flt;
  logic cts, dsr, ri, dcd, rx_in;
  logic [3:0] mprev, dlt;
  logic [15:0] bcnt;
  logic tick;
  asp_ser_e tx_st, rx_st;
  logic [4:0] tx_tc, rx_tc;
  logic [2:0] tx_bi, rx_bi;
  logic [7:0] tx_sh, rx_sh;
  logic tx_bit, rx_pe;
  logic [9:0] to_cnt;
  logic [3:0] iid;
  logic [7:0] rd_mux;

  wire loop = mcr[`ASP_MCR_LOOP];
  wire afe = mcr[`ASP_MCR_AFE];
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite & mapped(paddr);
  wire rd = acc & ~pwrite & mapped(paddr);
  wire [15:0] div = {dlm, dll};
  wire [2:0] nbits = {1'b0, lcr.wls} + 3'h4;
  wire wr_thr = wr && paddr == `ASP_OFS_DATA && !lcr.dlab;
  wire rd_rbr = rd && paddr == `ASP_OFS_DATA && !lcr.dlab;
  wire wr_fcr = wr && paddr == `ASP_OFS_IIR;
  wire rd_iir = rd && paddr == `ASP_OFS_IIR;
  wire rd_lsr = rd && paddr == `ASP_OFS_LSR;
  wire rd_msr = rd && paddr == `ASP_OFS_MSR;
  wire fifo_rst_tx = wr_fcr && (pwdata[2] || pwdata[0] != fifo_en);
  wire fifo_rst_rx = wr_fcr && (pwdata[1] || pwdata[0] != fifo_en);
  wire tx_push = wr_thr && tx_cnt < cap;
  wire tx_pop = ce && tick && tx_st == ASP_IDLE && tx_cnt != 7'h00 && !tx_paused
    && (!afe || cts); // RL14
  wire rx_pop = rd_rbr && rx_cnt != 7'h00;
  wire rx_done = ce && tick && rx_st == ASP_STOP && rx_tc == `ASP_TICKS_BIT - 5'h01;
  wire rx_push = rx_done && rx_cnt < cap;
  wire stop_hit = !rx_in && rx_sh == 8'h00;
  asp_rxword_s rx_word;
  assign rx_word = '{bi: stop_hit, fe: !rx_in, pe: rx_pe, data: rx_sh};
  wire rx_hit = fifo_en ? rx_cnt >= trig : rx_cnt != 7'h00;
  wire timeout = fifo_en && to_cnt == `ASP_TIMEOUT_TICKS;
  wire temt = tx_cnt == 7'h00 && tx_st == ASP_IDLE;
  wire [4:0] stop_len = !lcr.stb ? `ASP_TICKS_BIT :
    (lcr.wls == 2'b00 ? `ASP_TICKS_1P5 : `ASP_TICKS_2); // RL3

  // Single character holding in 16450 mode
  assign cap = fifo_en ? `ASP_FIFO_DEPTH : `ASP_HOLD_DEPTH; // RL7 RL8
  always_comb begin
    unique case (rx_trig)
      2'b00: trig = `ASP_TRIG_1;
      2'b01: trig = `ASP_TRIG_16;
      2'b10: trig = `ASP_TRIG_32;
      2'b11: trig = `ASP_TRIG_56;
    endcase
  end

  // Zero wait states; unmapped addresses error out
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped(paddr);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lcr <= asp_lcr_s'(`ASP_LCR_RESET);
      ier <= 4'h0;
      mcr <= 6'h00;
      scr <= 8'h00;
      dll <= `ASP_DIV_RESET;
      dlm <= 8'h00;
      fifo_en <= 1'b0;
      rx_trig <= 2'b00;
      flow_sw <= 1'b0;
    end else if (ce && wr) begin
      unique case (paddr)
        `ASP_OFS_DATA: if (lcr.dlab) dll <= pwdata[7:0]; // RL5
        `ASP_OFS_IER: begin
          if (lcr.dlab) dlm <= pwdata[7:0]; // RL5
          else ier <= pwdata[3:0]; // RL10
        end
        `ASP_OFS_IIR: begin
          fifo_en <= pwdata[0]; // RL7
          rx_trig <= pwdata[7:6];
        end
        `ASP_OFS_LCR: lcr <= asp_lcr_s'(pwdata[7:0]); // RL2 RL4
        `ASP_OFS_MCR: mcr <= pwdata[5:0];
        `ASP_OFS_SCR: scr <= pwdata[7:0]; // RL6
        `ASP_OFS_FLOW: flow_sw <= pwdata[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (paddr)
      `ASP_OFS_DATA: rd_mux = lcr.dlab ? dll : rxq[rx_rp].data; // RL1
      `ASP_OFS_IER: rd_mux = lcr.dlab ? dlm : {4'h0, ier};
      `ASP_OFS_IIR: rd_mux = {fifo_en, fifo_en, 2'b00, iid}; // RL9
      `ASP_OFS_LCR: rd_mux = lcr;
      `ASP_OFS_MCR: rd_mux = {2'b00, mcr};
      `ASP_OFS_LSR: rd_mux = {rx_err, temt, tx_cnt == 7'h00, bi, fe, pe, oe, rx_cnt != 7'h00};
      `ASP_OFS_MSR: rd_mux = {dcd, ri, dsr, cts, dlt};
      `ASP_OFS_SCR: rd_mux = scr; // RL6
      `ASP_OFS_FLOW: rd_mux = {6'h00, tx_paused, flow_sw};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) prdata <= 32'h0;
    else if (ce && setup && !pwrite) prdata <= {24'h0, rd_mux};
  end

  // Modem and serial inputs: three flops, change taken when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Idle pin levels, so no false modem change follows reset
      s1 <= `ASP_PIN_IDLE;
      s2 <= `ASP_PIN_IDLE;
      s3 <= `ASP_PIN_IDLE;
      flt <= `ASP_PIN_IDLE;
    end else if (ce) begin
      s1 <= {ring_indicator_in, carrier_detect_in, set_ready_in, clear_to_send_in,
        serial_in_line}; // RL13
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 5; i++) if (s2[i] == s3[i]) flt[i] <= s3[i];
    end
  end

  // Loop-back: outputs feed the inputs inside, pins stay inactive
  assign rx_in = loop ? tx_bit : flt[0]; // RL15
  assign cts = loop ? mcr[1] : flt[1];
  assign dsr = loop ? mcr[0] : flt[2];
  assign dcd = loop ? mcr[3] : flt[3];
  assign ri = loop ? mcr[2] : flt[4];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      serial_out_line <= 1'b1;
      request_to_send_out <= 1'b0;
      terminal_ready_out <= 1'b0;
    end else if (ce) begin
      serial_out_line <= loop ? 1'b1 : tx_bit & ~lcr.brk; // RL15 RL16
      request_to_send_out <= !loop && mcr[1] && (!afe || rx_cnt < trig); // RL13 RL14
      terminal_ready_out <= !loop && mcr[0]; // RL13
    end
  end

  // Modem status deltas; a change in the read cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mprev <= 4'h0;
      dlt <= 4'h0;
    end else if (ce) begin
      mprev <= {dcd, ri, dsr, cts};
      dlt <= (rd_msr ? 4'h0 : dlt) | {dcd ^ mprev[3], mprev[2] & ~ri, dsr ^ mprev[1],
        cts ^ mprev[0]}; // RL11
    end
  end

  // Divisor zero behaves as one; tick is sixteen times the bit rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bcnt <= 16'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= bcnt + 16'h1 >= div; // RL5
      bcnt <= (bcnt + 16'h1 >= div) ? 16'h0 : bcnt + 16'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && tx_push) txq[tx_wp] <= pwdata[7:0];
    if (ce && rx_push) rxq[rx_wp] <= rx_word;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && fifo_rst_tx)) begin
      tx_wp <= 6'h0;
      tx_rp <= 6'h0;
      tx_cnt <= 7'h0;
    end else if (ce) begin
      if (tx_push) tx_wp <= tx_wp + 6'h1;
      if (tx_pop) tx_rp <= tx_rp + 6'h1;
      tx_cnt <= tx_cnt + {6'h0, tx_push} - {6'h0, tx_pop}; // RL8
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && fifo_rst_rx)) begin
      rx_wp <= 6'h0;
      rx_rp <= 6'h0;
      rx_cnt <= 7'h0;
    end else if (ce) begin
      if (rx_push) rx_wp <= rx_wp + 6'h1;
      if (rx_pop) rx_rp <= rx_rp + 6'h1;
      rx_cnt <= rx_cnt + {6'h0, rx_push} - {6'h0, rx_pop}; // RL8
    end
  end

  // Transmitter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st <= ASP_IDLE;
      tx_bit <= 1'b1;
      tx_tc <= 5'h0;
      tx_bi <= 3'h0;
      tx_sh <= 8'h0;
    end else if (ce && tick) begin
      tx_tc <= tx_tc + 5'h1;
      unique case (tx_st)
        ASP_IDLE: begin
          tx_bit <= 1'b1; // RL16
          if (tx_pop) begin
            tx_sh <= txq[tx_rp]; // RL1
            tx_st <= ASP_START;
            tx_bit <= 1'b0; // RL16
            tx_tc <= 5'h0;
          end
        end
        ASP_START: if (tx_tc == `ASP_TICKS_BIT - 5'h01) begin
          tx_st <= ASP_DATA;
          tx_bit <= tx_sh[0]; // RL16
          tx_bi <= 3'h0;
          tx_tc <= 5'h0;
        end
        ASP_DATA: if (tx_tc == `ASP_TICKS_BIT - 5'h01) begin
          tx_tc <= 5'h0;
          tx_bi <= tx_bi + 3'h1;
          if (tx_bi == nbits) begin // RL2
            tx_st <= lcr.pen ? ASP_PAR : ASP_STOP;
            tx_bit <= lcr.pen ? par_bit(lcr, tx_sh) : 1'b1; // RL4
          end else begin
            tx_bit <= tx_sh[tx_bi + 3'h1];
          end
        end
        ASP_PAR: if (tx_tc == `ASP_TICKS_BIT - 5'h01) begin
          tx_st <= ASP_STOP;
          tx_bit <= 1'b1;
          tx_tc <= 5'h0;
        end
        // Last stop tick is spent in idle, so queued frames follow with no gap
        ASP_STOP: if (tx_tc == stop_len - 5'h02) begin // RL3
          tx_st <= ASP_IDLE;
          tx_tc <= 5'h0;
        end
        default: tx_st <= ASP_IDLE;
      endcase
    end
  end

  // Receiver: start checked at mid bit, then one sample per bit time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st <= ASP_IDLE;
      rx_tc <= 5'h0;
      rx_bi <= 3'h0;
      rx_sh <= 8'h0;
      rx_pe <= 1'b0;
    end else if (ce && tick) begin
      rx_tc <= rx_tc + 5'h1;
      unique case (rx_st)
        ASP_IDLE: begin
          rx_tc <= 5'h0;
          if (!rx_in) rx_st <= ASP_START; // RL16
        end
        ASP_START: if (rx_tc == `ASP_TICKS_HALF - 5'h01) begin
          rx_st <= rx_in ? ASP_IDLE : ASP_DATA;
          rx_tc <= 5'h0;
          rx_bi <= 3'h0;
          rx_sh <= 8'h0;
          rx_pe <= 1'b0;
        end
        ASP_DATA: if (rx_tc == `ASP_TICKS_BIT - 5'h01) begin
          rx_tc <= 5'h0;
          rx_sh[rx_bi] <= rx_in; // RL1 RL16
          rx_bi <= rx_bi + 3'h1;
          if (rx_bi == nbits) rx_st <= lcr.pen ? ASP_PAR : ASP_STOP; // RL2
        end
        ASP_PAR: if (rx_tc == `ASP_TICKS_BIT - 5'h01) begin
          rx_tc <= 5'h0;
          rx_pe <= rx_in != par_bit(lcr, rx_sh); // RL4
          rx_st <= ASP_STOP;
        end
        ASP_STOP: if (rx_tc == `ASP_TICKS_BIT - 5'h01) rx_st <= ASP_IDLE;
        default: rx_st <= ASP_IDLE;
      endcase
    end
  end

  // Line status: sticky, set wins over the clear by a read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {oe, pe, fe, bi, rx_err} <= 5'h0;
    end else if (ce) begin
      oe <= (oe & ~rd_lsr) | (rx_done & ~rx_push); // RL11
      pe <= (pe & ~rd_lsr) | (rx_done & rx_word.pe);
      fe <= (fe & ~rd_lsr) | (rx_done & rx_word.fe);
      bi <= (bi & ~rd_lsr) | (rx_done & rx_word.bi);
      rx_err <= (rx_err & ~rd_lsr) | (rx_push & fifo_en & (rx_word.pe | rx_word.fe |
        rx_word.bi));
    end
  end

  // XON/XOFF seen on receive pauses and resumes sending
  always_ff @(posedge clk_sys) begin
    if (sys_rst) tx_paused <= 1'b0;
    else if (ce && (!flow_sw || loop)) tx_paused <= 1'b0;
    else if (ce && rx_push && rx_sh == `ASP_XOFF) tx_paused <= 1'b1; // RL14
    else if (ce && rx_push && rx_sh == `ASP_XON) tx_paused <= 1'b0; // RL14
  end

  // Character timeout counted in sixteenth-bit ticks while data waits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) to_cnt <= 10'h0;
    else if (ce) begin
      if (rx_cnt == 7'h00 || rx_push || rx_pop) to_cnt <= 10'h0;
      else if (tick && !timeout) to_cnt <= to_cnt + 10'h1; // RL11
    end
  end

  // Empty event re-armed by enabling it; cleared by a data write or an IIR read that reports it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      thre_q <= 1'b1;
      thre_pend <= 1'b0;
    end else if (ce) begin
      thre_q <= tx_cnt == 7'h00;
      thre_pend <= (thre_pend && !wr_thr && !(rd_iir && iid == `ASP_IID_THRE))
        || (tx_cnt == 7'h00 && !thre_q)
        || (wr && paddr == `ASP_OFS_IER && !lcr.dlab && pwdata[1] && !ier[1]
          && tx_cnt == 7'h00); // RL12
    end
  end

  always_comb begin
    if (ier[2] && (oe || pe || fe || bi)) iid = `ASP_IID_LINE; // RL9 RL10 RL11
    else if (ier[0] && rx_hit) iid = `ASP_IID_RXDATA;
    else if (ier[0] && timeout) iid = `ASP_IID_TIMEOUT;
    else if (ier[1] && thre_pend) iid = `ASP_IID_THRE; // RL12
    else if (ier[3] && dlt != 4'h0) iid = `ASP_IID_MODEM;
    else iid = `ASP_IID_NONE;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) irq <= 1'b0;
    else if (ce) irq <= ~iid[0]; // RL9
  end

endmodule

// >>> core/asp_defines.svh
// Register map, field positions and timing counts of the serial port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_OFS_DATA 8'h00
`define ASP_OFS_IER 8'h04
`define ASP_OFS_IIR 8'h08
`define ASP_OFS_LCR 8'h0c
`define ASP_OFS_MCR 8'h10
`define ASP_OFS_LSR 8'h14
`define ASP_OFS_MSR 8'h18
`define ASP_OFS_SCR 8'h1c
`define ASP_OFS_FLOW 8'h20
`define ASP_FIFO_DEPTH 7'h40
`define ASP_HOLD_DEPTH 7'h01
`define ASP_TRIG_1 7'h01
`define ASP_TRIG_16 7'h10
`define ASP_TRIG_32 7'h20
`define ASP_TRIG_56 7'h38
`define ASP_TICKS_BIT 5'h10
`define ASP_TICKS_HALF 5'h08
`define ASP_TICKS_1P5 5'h18
`define ASP_TICKS_2 5'h20
`define ASP_TIMEOUT_TICKS 10'h280
`define ASP_IID_LINE 4'h6
`define ASP_IID_RXDATA 4'h4
`define ASP_IID_TIMEOUT 4'hc
`define ASP_IID_THRE 4'h2
`define ASP_IID_MODEM 4'h0
`define ASP_IID_NONE 4'h1
`define ASP_XON 8'h11
`define ASP_XOFF 8'h13
`define ASP_LCR_RESET 8'h03
`define ASP_DIV_RESET 8'h01
`define ASP_MCR_LOOP 4
`define ASP_MCR_AFE 5
`define ASP_PIN_IDLE 5'h01
`endif

// >>> core/asp_pkg.sv
// Types shared by the serial port design
package asp_pkg;
  typedef struct packed {
    logic dlab;
    logic brk;
    logic stick;
    logic eps;
    logic pen;
    logic stb;
    logic [1:0] wls;
  } asp_lcr_s;
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } asp_rxword_s;
  typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_PAR, ASP_STOP} asp_ser_e;
endpackage

// >>> dv/asp_uart_sva.sv
// Port-level property checker for the serial port
`timescale 1ns/1ns
`include "asp_defines.svh"
module asp_uart_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_line,
  input wire logic request_to_send_out,
  input wire logic terminal_ready_out,
  input wire logic irq
);
  logic [7:0] scr_q;
  logic scr_ok;
  logic [5:0] mcr_q;
  logic [3:0] ier_q;
  logic dlab_q;
  logic wr_en;
  logic rd_acc;
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_acc = psel && penable && !pwrite;
  // Shadows of registers whose effect shows at the pins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scr_q <= 8'h00;
      scr_ok <= 1'b0;
      mcr_q <= 6'h00;
      ier_q <= 4'h0;
      dlab_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `ASP_OFS_SCR) begin
        scr_q <= pwdata[7:0];
        scr_ok <= 1'b1;
      end
      if (paddr == `ASP_OFS_MCR) mcr_q <= pwdata[5:0];
      if (paddr == `ASP_OFS_IER && !dlab_q) ier_q <= pwdata[3:0];
      if (paddr == `ASP_OFS_LCR) dlab_q <= pwdata[7];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_READY: assert property (psel |-> pready)
    else $error("no ready in transfer");
  AST_UNMAPPED: assert property (rd_acc && paddr > `ASP_OFS_FLOW |-> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  AST_UPPER_ZERO: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_SCRATCH: assert property (
    rd_acc && paddr == `ASP_OFS_SCR && scr_ok |-> prdata[7:0] == scr_q)
    else $error("scratch readback wrong");
  AST_RESET_IDLE: assert property (
    $fell(sys_rst) |-> serial_out_line && !irq && !request_to_send_out && !terminal_ready_out)
    else $error("outputs not idle after reset");
  AST_LOW_MIN: assert property ($fell(serial_out_line) |-> !serial_out_line [*8])
    else $error("low bit too short");
  AST_HIGH_MIN: assert property ($rose(serial_out_line) |-> serial_out_line [*8])
    else $error("high bit too short");
  AST_LOOP_QUIET: assert property (
    $past(mcr_q[4], 2) && mcr_q[4] |-> serial_out_line && !request_to_send_out
    && !terminal_ready_out)
    else $error("pins active in loop-back");
  AST_MODEM_OUT: assert property (
    $past(mcr_q, 2) == mcr_q && mcr_q[5:4] == 2'b00
    |-> {request_to_send_out, terminal_ready_out} == mcr_q[1:0])
    else $error("modem outputs differ from control");
  AST_IRQ_MASKED: assert property ($past(ier_q, 2) == 4'h0 && ier_q == 4'h0 |-> !irq)
    else $error("interrupt with all causes off");
endmodule
bind asp_uart asp_uart_sva u_sva (.clk_sys, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .serial_out_line, .request_to_send_out,
  .terminal_ready_out, .irq);

// >>> dv/asp_peer.sv
// Far-side serial peer: sends frames, samples and times received ones
`timescale 1ns/1ns
module asp_peer (
  input wire logic clk_sys,
  input wire logic serial_out_line,
  output logic serial_in_line,
  output logic clear_to_send_in,
  output logic set_ready_in,
  output logic carrier_detect_in,
  output logic ring_indicator_in
);
  int cyc = 0;
  initial begin
    serial_in_line = 1'b1;
    {clear_to_send_in, set_ready_in, carrier_detect_in, ring_indicator_in} = 4'h0;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // Divisor 1 assumed: 16 clocks per bit
  task automatic send(input logic [11:0] fr, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_sys);
      serial_in_line <= fr[i];
      repeat (15) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    serial_in_line <= 1'b1;
  endtask
  task automatic modem(input logic [3:0] v);
    @(posedge clk_sys);
    {clear_to_send_in, set_ready_in, carrier_detect_in, ring_indicator_in} <= v;
  endtask
  // Stops at the middle of the first stop bit so a back-to-back start is not missed
  task automatic take(input int nb, input int lim, output logic [11:0] fr, output int t0);
    fr = 12'hfff;
    t0 = -1;
    for (int i = 0; i < lim && t0 < 0; i++) begin
      @(posedge clk_sys);
      if (!serial_out_line) t0 = cyc;
    end
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      fr[i] = serial_out_line;
      if (i < nb - 1) repeat (16) @(posedge clk_sys);
    end
  endtask
endmodule

// >>> dv/test_async_serial_port_16550.sv
// Self-checking bench for the serial port
`timescale 1ns/1ns
`include "asp_defines.svh"
module test_async_serial_port_16550;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, serial_in_line, clear_to_send_in, set_ready_in, carrier_detect_in;
  logic ring_indicator_in, serial_out_line, request_to_send_out, terminal_ready_out, irq, err;
  logic [11:0] f, g;
  int fail_count = 0;
  int checks = 0;
  int t0, t1, n, k;
  // Transmit rows: line control, byte, start-to-start spacing in clocks
  logic [7:0] tl[6] = '{8'h03, 8'h00, 8'h04, 8'h0f, 8'h1a, 8'h29};
  logic [7:0] td[6] = '{8'h55, 8'h1d, 8'h0e, 8'hc3, 8'h6b, 8'h2e};
  int tp[6] = '{160, 112, 120, 192, 160, 144};
  // Register rows: written, then read back
  logic [7:0] ra[9] = '{`ASP_OFS_SCR, `ASP_OFS_SCR, `ASP_OFS_LCR, `ASP_OFS_DATA, `ASP_OFS_IER,
    `ASP_OFS_DATA, `ASP_OFS_IER, `ASP_OFS_LCR, `ASP_OFS_MCR};
  logic [7:0] rv[9] = '{8'ha5, 8'h5a, 8'h83, 8'h34, 8'h12, 8'h01, 8'h00, 8'h03, 8'h03};
  asp_uart DUT (.clk_sys, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_in_line, .clear_to_send_in, .set_ready_in,
    .carrier_detect_in, .ring_indicator_in, .serial_out_line, .request_to_send_out,
    .terminal_ready_out, .irq);
  asp_peer peer (.clk_sys, .serial_out_line, .serial_in_line, .clear_to_send_in,
    .set_ready_in, .carrier_detect_in, .ring_indicator_in);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // Frame bits from start onward, idle ones above the first stop
  function automatic logic [11:0] mk(input logic [7:0] l, input logic [7:0] d);
    logic [11:0] fr;
    int nb;
    nb = 5 + l[1:0];
    fr = 12'hfff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) fr[i + 1] = d[i];
    if (l[3]) fr[nb + 1] = l[5] ? !l[4] : ((^(d & ((8'h1 << nb) - 8'h1))) ^ !l[4]);
    return fr;
  endfunction
  task automatic summarize();
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("idle_pins", 4'h8, {serial_out_line, request_to_send_out, terminal_ready_out, irq});
    rd(`ASP_OFS_LCR);
    chk("lcr_reset", 32'h3, q);
    rd(`ASP_OFS_IIR);
    chk("iir_reset", 32'h1, q);
    rd(8'h24);
    chk("unmapped", 32'h8000_0000, {err, q[30:0]});
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rv[i]);
      rd(ra[i]);
      chk("reg_rw", rv[i], q);
    end
    ce <= 1'b0;
    wr(`ASP_OFS_SCR, 8'h3c);
    ce <= 1'b1;
    rd(`ASP_OFS_SCR);
    chk("ce_freeze", 8'h5a, q);
    repeat (3) @(posedge clk_sys);
    chk("modem_pins", 2'h3, {request_to_send_out, terminal_ready_out});
    wr(`ASP_OFS_MCR, 8'h00);
    wr(`ASP_OFS_IIR, 8'h07);
    rd(`ASP_OFS_IIR);
    chk("fifo_mode", 32'hc1, q);
    for (int i = 0; i < 6; i++) begin
      wr(`ASP_OFS_LCR, tl[i]);
      n = 7 + tl[i][1:0] + tl[i][3];
      fork
        begin
          peer.take(n, 4000, f, t0);
          peer.take(n, 4000, g, t1);
        end
        begin
          wr(`ASP_OFS_DATA, td[i]);
          wr(`ASP_OFS_DATA, ~td[i]);
        end
      join
      chk("frame", mk(tl[i], td[i]), f);
      chk("frame_next", mk(tl[i], ~td[i]), g);
      chk("spacing", tp[i], t1 - t0);
    end
    // Queue full, then holding register only: the extra byte is the one lost
    wr(`ASP_OFS_LCR, 8'h03);
    for (int m = 0; m < 2; m++) begin
      k = m ? 1 : 64;
      wr(`ASP_OFS_IIR, m ? 8'h00 : 8'h07);
      for (int i = 0; i <= k; i++) peer.send(mk(8'h03, 8'(i) ^ 8'ha5), 10);
      rd(`ASP_OFS_LSR);
      chk("overrun", 2'h3, q[1:0]);
      for (int i = 0; i < k; i++) begin
        rd(`ASP_OFS_DATA);
        chk("rx_byte", 8'(i) ^ 8'ha5, q);
      end
      rd(`ASP_OFS_LSR);
      chk("drained", 1'b0, q[0]);
    end
    wr(`ASP_OFS_LCR, 8'h1b);
    peer.send(mk(8'h1b, 8'h96) ^ 12'h200, 11);
    rd(`ASP_OFS_LSR);
    chk("parity_err", 1'b1, q[2]);
    rd(`ASP_OFS_DATA);
    chk("parity_byte", 8'h96, q);
    rd(`ASP_OFS_LSR);
    chk("err_clear", 1'b0, q[2]);
    wr(`ASP_OFS_LCR, 8'h03);
    wr(`ASP_OFS_IER, 8'h02);
    repeat (4) @(posedge clk_sys);
    chk("irq_thre", 1'b1, irq);
    rd(`ASP_OFS_IIR);
    chk("iid_thre", 4'h2, q[3:0]);
    repeat (4) @(posedge clk_sys);
    chk("irq_ack", 1'b0, irq);
    peer.send(mk(8'h03, 8'h5e), 10);
    wr(`ASP_OFS_IER, 8'h0f);
    rd(`ASP_OFS_IIR);
    chk("iid_prio", 4'h4, q[3:0]);
    rd(`ASP_OFS_DATA);
    rd(`ASP_OFS_IIR);
    chk("iid_none", 4'h1, q[3:0]);
    wr(`ASP_OFS_IER, 8'h08);
    peer.modem(4'h8);
    repeat (8) @(posedge clk_sys);
    chk("irq_modem", 1'b1, irq);
    rd(`ASP_OFS_IIR);
    chk("iid_modem", 4'h0, q[3:0]);
    rd(`ASP_OFS_MSR);
    chk("msr_cts", 5'h11, q[4:0]);
    wr(`ASP_OFS_IER, 8'h00);
    wr(`ASP_OFS_MCR, 8'h22);
    peer.modem(4'h0);
    repeat (8) @(posedge clk_sys);
    chk("rts_flow", 1'b1, request_to_send_out);
    fork
      peer.take(10, 600, f, t0);
      wr(`ASP_OFS_DATA, 8'h81);
    join
    chk("paused", -1, t0);
    fork
      peer.take(10, 600, f, t0);
      peer.modem(4'h8);
    join
    chk("resumed", mk(8'h03, 8'h81), f);
    wr(`ASP_OFS_FLOW, 8'h01);
    peer.send(mk(8'h03, `ASP_XOFF), 10);
    fork
      peer.take(10, 600, f, t0);
      wr(`ASP_OFS_DATA, 8'h42);
    join
    chk("xoff_paused", -1, t0);
    rd(`ASP_OFS_DATA);
    chk("xoff_byte", `ASP_XOFF, q);
    fork
      peer.take(10, 600, f, t0);
      peer.send(mk(8'h03, `ASP_XON), 10);
    join
    chk("xon_resumed", mk(8'h03, 8'h42), f);
    rd(`ASP_OFS_DATA);
    chk("xon_byte", `ASP_XON, q);
    wr(`ASP_OFS_MCR, 8'h13);
    wr(`ASP_OFS_DATA, 8'h3c);
    repeat (200) @(posedge clk_sys);
    chk("loop_pins", 3'h4, {serial_out_line, request_to_send_out, terminal_ready_out});
    rd(`ASP_OFS_DATA);
    chk("loop_data", 8'h3c, q);
    rd(`ASP_OFS_MSR);
    chk("loop_msr", 4'h3, q[7:4]);
    summarize();
  end
endmodule
